// File: include/bbde_params.svh
/*
 file: constants of the bisync buffer descriptor engine: apb offsets,
 descriptor field positions and reset values.
 assumes: included by the engine and the test bench; 32-bit apb, byte addresses.
*/
// Behaviour
// - parity select: odd, zero, even, one
// - parity only under sum check, live changes
// - close rx buffer on control, error, full, command
// - rx descriptor: status, length +2, pointer +4
// - engine owns descriptor while empty flag set
// - rx wrap flag returns to table start
// - rx interrupt flag sets buffer event
// - continuous reuse keeps empty unless error
// - last flag and octet count on closing buffer
// - pll fault flag on recovery error
// - data lost and carrier lost flags
// - rx length counts every stored character
// - rx buffer pointer may be any byte
// - engine writes tx status after sending
// - ready cleared when sent or failed
// - tx wrap flag returns to ring start
// - tx interrupt flag sets done or error event
// - last in message ends block, normal mode
// - send check after picks check, syn or idle
// - continuous reuse keeps ready set
// - tx error clears ready despite reuse
// - check restart resets check before buffer
// - lead escape sends one escape first
// - check include gates buffer into check
`ifndef BBDE_PARAMS_SVH
`define BBDE_PARAMS_SVH
`define BBDE_MODE_OFF 12'h000
`define BBDE_RXSTART_OFF 12'h004
`define BBDE_TXSTART_OFF 12'h008
`define BBDE_MAXLEN_OFF 12'h00c
`define BBDE_CMD_OFF 12'h010
`define BBDE_EVENT_OFF 12'h014
`define BBDE_STATUS_OFF 12'h018
`define BBDE_DMEM_BASE 5'h02
`define BBDE_MAXLEN_RST 16'h0010
`define BBDE_CHECK_LRC 2'h3
`define BBDE_B_OWN 15
`define BBDE_B_WRAP 13
`define BBDE_B_INT 12
`define BBDE_B_LAST 11
`define BBDE_B_FIRST 10
`define BBDE_B_SENDCHK 10
`define BBDE_B_REUSE 9
`define BBDE_B_RESTART 8
`define BBDE_B_PLL 7
`define BBDE_B_LEADESC 7
`define BBDE_B_ESCAFTER 6
`define BBDE_B_INCLUDE 5
`define BBDE_B_LOST 1
`define BBDE_B_STARVED 1
`define BBDE_B_CARRIER 0
`define BBDE_B_CTS 0
`define BBDE_RX_RSVD_MASK 16'hff60
`endif

// File: include/bbde_pkg.sv
/*
 file: types of the bisync buffer descriptor engine.
 assumes: bbde_params.svh is on the include path.
*/
package bbde_pkg;
   typedef enum logic [1:0] {END_NONE, END_BCS, END_SYN, END_IDLE} bbde_end_t;
   typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_CLOSE} bbde_tx_state_t;
endpackage

// File: hw/bbde_engine.sv
/*
 file: bisync buffer descriptor engine with apb slave and descriptor ram.
 assumes: line-side strobes come from logic on pclk; buffer memory is
 written through the rx_wr_* port and read by the transmitter itself.
*/
`timescale 1ns/1ps
`include "bbde_params.svh"
`default_nettype none
module bbde_engine import bbde_pkg::*; (
   input wire logic pclk, // 10 MHz system clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // unmapped address
   input wire logic rx_char_valid, // received character strobe
   input wire logic [7:0] rx_char, // received character
   input wire logic rx_ctrl_char, // character is a user control char
   input wire logic rx_pll_fault, // clock recovery error
   input wire logic rx_overrun, // receive fifo overrun
   input wire logic rx_carrier_lost, // carrier detect negated
   input wire logic [6:0] tx_char, // character for parity
   input wire logic tx_sent, // buffer fully sent
   input wire logic tx_starved, // transmitter underrun
   input wire logic tx_cts_lost, // clear to send lost
   output logic rx_wr_valid, // buffer byte write strobe
   output logic [31:0] rx_wr_addr, // buffer byte address
   output logic [7:0] rx_wr_data, // buffer byte
   output logic tx_start, // one-cycle start of a buffer
   output logic [31:0] tx_buf_addr, // first byte of tx buffer
   output logic [15:0] tx_buf_len, // octets to send
   output logic tx_lead_escape, // send escape before buffer
   output logic tx_check_restart, // clear block check first
   output logic tx_check_include, // buffer enters block check
   output bbde_end_t tx_end_action, // what follows last char
   output logic tx_escape_after, // stay in escape mode after
   output logic tx_parity_en, // parity bit is sent
   output logic tx_parity_bit // parity bit for tx_char
);
   logic [31:0] dmem [0:31];
   logic [6:0] mode_reg;
   logic [3:0] rx_start_reg, tx_start_reg, rx_idx_reg, tx_idx_reg;
   logic [15:0] maxlen_reg, rx_len_reg, rx_word_reg, tx_word_reg;
   logic [3:0] event_reg;
   logic rx_pend_reg, rx_first_reg;
   bbde_tx_state_t tx_state_reg;
   logic acc_wr, mem_hit, apb_mem_wr, rx_grant, tx_grant, cmd_close, cmd_hunt;
   logic [15:0] rx_st, tx_st, rx_len_next, rx_word_next;
   logic [31:0] rx_ptr, rd_mux;
   logic rx_own, rx_err, rx_store, rx_full, rx_close, rx_busy;
   logic tx_err;
   logic [3:0] ev_set;

   // decodes the descriptor ram word hit by an apb address
   function automatic logic dmem_sel(input logic [11:0] a);
      dmem_sel = (a[11:7] == `BBDE_DMEM_BASE);
   endfunction

   // parity for the seven data bits under the selected mode
   function automatic logic parity_of(input logic [1:0] sel, input logic [6:0] c);
      case (sel)
         2'h0: parity_of = ~(^c);
         2'h1: parity_of = 1'b0;
         2'h2: parity_of = ^c;
         default: parity_of = 1'b1;
      endcase
   endfunction

   // apb decode; writes act at the edge that samples pready high
   assign acc_wr = psel & penable & pready & pwrite;
   assign mem_hit = dmem_sel(paddr);
   assign apb_mem_wr = acc_wr & mem_hit;
   assign cmd_hunt = acc_wr & (paddr == `BBDE_CMD_OFF) & pwdata[0];
   assign cmd_close = acc_wr & (paddr == `BBDE_CMD_OFF) & (pwdata[0] | pwdata[1]);

   // bus wins the ram port; engine writes wait a cycle, lines are slow
   assign rx_grant = rx_pend_reg & ~apb_mem_wr;
   assign tx_grant = (tx_state_reg == TX_CLOSE) & ~apb_mem_wr & ~rx_pend_reg;

   // read mux, evaluated in the setup cycle
   always_comb begin
      rd_mux = 32'h0;
      if (mem_hit) begin
         rd_mux = dmem[paddr[6:2]];
      end else begin
         case (paddr)
            `BBDE_MODE_OFF: rd_mux = {25'h0, mode_reg};
            `BBDE_RXSTART_OFF: rd_mux = {28'h0, rx_start_reg};
            `BBDE_TXSTART_OFF: rd_mux = {28'h0, tx_start_reg};
            `BBDE_MAXLEN_OFF: rd_mux = {16'h0, maxlen_reg};
            `BBDE_EVENT_OFF: rd_mux = {28'h0, event_reg};
            `BBDE_STATUS_OFF: rd_mux = {20'h0, tx_state_reg, rx_pend_reg, rx_first_reg,
                                        tx_idx_reg, rx_idx_reg};
            default: rd_mux = 32'h0;
         endcase
      end
   end

   // one wait-free access phase: pready rises for the access cycle only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel & ~penable;
         prdata <= rd_mux;
         pslverr <= psel & ~penable & ~mem_hit & (paddr > `BBDE_STATUS_OFF);
      end
   end

   // configuration registers: mode is enables, check select, parity, fill
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= 7'h0;
         rx_start_reg <= 4'h0;
         tx_start_reg <= 4'h0;
         maxlen_reg <= `BBDE_MAXLEN_RST;
      end else if (acc_wr) begin
         case (paddr)
            `BBDE_MODE_OFF: mode_reg <= pwdata[6:0];
            `BBDE_RXSTART_OFF: rx_start_reg <= pwdata[3:0];
            `BBDE_TXSTART_OFF: tx_start_reg <= pwdata[3:0];
            `BBDE_MAXLEN_OFF: maxlen_reg <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // descriptor ram; no reset, software builds tables before enabling
   always_ff @(posedge pclk) begin
      if (apb_mem_wr) begin
         dmem[paddr[6:2]] <= pwdata;
      end else if (rx_grant) begin
         dmem[{rx_idx_reg, 1'b0}] <= {rx_len_reg, rx_word_reg};
      end else if (tx_grant) begin
         dmem[{tx_idx_reg, 1'b0}] <= {dmem[{tx_idx_reg, 1'b0}][31:16], tx_word_reg};
      end
   end

   // receive side view of the current descriptor
   assign rx_st = dmem[{rx_idx_reg, 1'b0}][15:0];
   assign rx_ptr = dmem[{rx_idx_reg, 1'b1}];
   assign rx_own = rx_st[`BBDE_B_OWN] & mode_reg[0] & ~rx_pend_reg;
   assign rx_err = rx_pll_fault | rx_overrun | rx_carrier_lost;
   assign rx_store = rx_char_valid & rx_own & ~rx_err;
   assign rx_len_next = rx_len_reg + {15'h0, rx_store};
   assign rx_full = rx_store & (rx_len_next >= maxlen_reg);
   assign rx_close = rx_own & (rx_err | cmd_close | (rx_store & (rx_ctrl_char | rx_full)));
   assign rx_busy = rx_char_valid & ~rx_own;

   // closing status word for the receive descriptor
   always_comb begin
      rx_word_next = rx_st & ~`BBDE_RX_RSVD_MASK;
      rx_word_next[`BBDE_B_WRAP] = rx_st[`BBDE_B_WRAP];
      rx_word_next[`BBDE_B_INT] = rx_st[`BBDE_B_INT];
      rx_word_next[`BBDE_B_REUSE] = rx_st[`BBDE_B_REUSE];
      rx_word_next[`BBDE_B_OWN] = rx_st[`BBDE_B_REUSE] & ~rx_err;
      rx_word_next[`BBDE_B_LAST] = rx_err | cmd_hunt | rx_ctrl_char;
      rx_word_next[`BBDE_B_FIRST] = rx_first_reg;
      rx_word_next[`BBDE_B_PLL] = rx_pll_fault;
      rx_word_next[`BBDE_B_LOST] = rx_overrun;
      rx_word_next[`BBDE_B_CARRIER] = rx_carrier_lost;
   end

   // receive walk: store characters, close, then move on in table order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_idx_reg <= 4'h0;
         rx_len_reg <= 16'h0;
         rx_word_reg <= 16'h0;
         rx_pend_reg <= 1'b0;
         rx_first_reg <= 1'b1;
      end else if (acc_wr && paddr == `BBDE_RXSTART_OFF) begin
         rx_idx_reg <= pwdata[3:0];
         rx_len_reg <= 16'h0;
         rx_pend_reg <= 1'b0;
         rx_first_reg <= 1'b1;
      end else if (rx_grant) begin
         rx_pend_reg <= 1'b0;
         rx_len_reg <= 16'h0;
         rx_first_reg <= rx_word_reg[`BBDE_B_LAST];
         if (rx_word_reg[`BBDE_B_WRAP]) begin
            rx_idx_reg <= rx_start_reg;
         end else begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
         end
      end else begin
         rx_len_reg <= rx_len_next;
         if (rx_close) begin
            rx_pend_reg <= 1'b1;
            rx_word_reg <= rx_word_next;
            rx_len_reg <= rx_len_next;
         end
      end
   end

   // byte write toward the buffer; pointer alignment is free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_wr_valid <= 1'b0;
         rx_wr_addr <= 32'h0;
         rx_wr_data <= 8'h0;
      end else begin
         rx_wr_valid <= rx_store;
         rx_wr_addr <= rx_ptr + {16'h0, rx_len_reg};
         rx_wr_data <= rx_char;
      end
   end

   // transmit descriptor view
   assign tx_st = dmem[{tx_idx_reg, 1'b0}][15:0];
   assign tx_err = tx_starved | tx_cts_lost;

   // transmit walk: start ready buffer, wait for the line, write back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_reg <= TX_IDLE;
         tx_idx_reg <= 4'h0;
         tx_word_reg <= 16'h0;
         tx_start <= 1'b0;
         tx_buf_addr <= 32'h0;
         tx_buf_len <= 16'h0;
         tx_lead_escape <= 1'b0;
         tx_check_restart <= 1'b0;
         tx_check_include <= 1'b0;
         tx_end_action <= END_NONE;
         tx_escape_after <= 1'b0;
      end else if (acc_wr && paddr == `BBDE_TXSTART_OFF) begin
         tx_idx_reg <= pwdata[3:0];
         tx_state_reg <= TX_IDLE;
         tx_start <= 1'b0;
      end else begin
         tx_start <= 1'b0;
         case (tx_state_reg)
            TX_IDLE: begin
               if (mode_reg[1] && tx_st[`BBDE_B_OWN]) begin
                  tx_start <= 1'b1;
                  tx_buf_addr <= dmem[{tx_idx_reg, 1'b1}];
                  tx_buf_len <= dmem[{tx_idx_reg, 1'b0}][31:16];
                  tx_lead_escape <= tx_st[`BBDE_B_LEADESC];
                  tx_check_restart <= tx_st[`BBDE_B_RESTART];
                  tx_check_include <= tx_st[`BBDE_B_INCLUDE];
                  tx_escape_after <= tx_st[`BBDE_B_ESCAFTER] & ~tx_st[`BBDE_B_LAST];
                  if (!tx_st[`BBDE_B_LAST]) begin
                     tx_end_action <= END_NONE;
                  end else if (tx_st[`BBDE_B_SENDCHK]) begin
                     tx_end_action <= END_BCS;
                  end else begin
                     tx_end_action <= mode_reg[6] ? END_IDLE : END_SYN;
                  end
                  tx_state_reg <= TX_RUN;
               end
            end
            TX_RUN: begin
               if (tx_sent || tx_err) begin
                  tx_word_reg <= tx_st;
                  tx_word_reg[`BBDE_B_OWN] <= tx_st[`BBDE_B_REUSE] & ~tx_err;
                  tx_word_reg[`BBDE_B_STARVED] <= tx_starved;
                  tx_word_reg[`BBDE_B_CTS] <= tx_cts_lost;
                  tx_state_reg <= TX_CLOSE;
               end
            end
            TX_CLOSE: begin
               if (tx_grant) begin
                  tx_state_reg <= TX_IDLE;
                  if (tx_word_reg[`BBDE_B_WRAP]) begin
                     tx_idx_reg <= tx_start_reg;
                  end else begin
                     tx_idx_reg <= tx_idx_reg + 4'h1;
                  end
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // events: rx buffer, tx done, tx error, busy; write one to clear
   assign ev_set[0] = rx_grant & rx_word_reg[`BBDE_B_INT];
   assign ev_set[1] = tx_grant & tx_word_reg[`BBDE_B_INT] & ~(|tx_word_reg[1:0]);
   assign ev_set[2] = tx_grant & tx_word_reg[`BBDE_B_INT] & (|tx_word_reg[1:0]);
   assign ev_set[3] = rx_busy;

   // a set in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_reg <= 4'h0;
      end else if (acc_wr && paddr == `BBDE_EVENT_OFF) begin
         event_reg <= (event_reg & ~pwdata[3:0]) | ev_set;
      end else begin
         event_reg <= event_reg | ev_set;
      end
   end

   // parity follows the live mode, so changes apply on the fly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_parity_en <= 1'b0;
         tx_parity_bit <= 1'b0;
      end else begin
         tx_parity_en <= (mode_reg[3:2] == `BBDE_CHECK_LRC);
         tx_parity_bit <= (mode_reg[3:2] == `BBDE_CHECK_LRC) ?
                          parity_of(mode_reg[5:4], tx_char) : 1'b0;
      end
   end

   chk_parity_high: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg[5:2] == 4'hf) |=> tx_parity_bit && tx_parity_en)
      else $error("forced one parity not sent");
   chk_parity_off: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg[3:2] != `BBDE_CHECK_LRC) |=> !tx_parity_en && !tx_parity_bit)
      else $error("parity sent without sum check");
   chk_rx_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_grant && rx_word_reg[`BBDE_B_WRAP] && !acc_wr) |=> rx_idx_reg == $past(rx_start_reg))
      else $error("rx table did not wrap");
   chk_rx_event: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_grant && rx_word_reg[`BBDE_B_INT]) |=> event_reg[0])
      else $error("rx buffer event missing");
   chk_rx_error_own: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_close && rx_err && !acc_wr) |=> rx_pend_reg && !rx_word_reg[`BBDE_B_OWN])
      else $error("empty flag kept after error");
   chk_rx_count: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_store && !rx_close && !acc_wr && !rx_grant) |=> rx_len_reg == $past(rx_len_reg) + 16'h1)
      else $error("rx length not counted");
   chk_tx_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_grant && tx_word_reg[`BBDE_B_WRAP] && !acc_wr) |=> tx_idx_reg == $past(tx_start_reg))
      else $error("tx ring did not wrap");
   chk_tx_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_state_reg == TX_RUN && tx_err && !acc_wr) |=> !tx_word_reg[`BBDE_B_OWN] ##1 1'b1)
      else $error("ready kept after tx error");
   chk_tx_event: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_grant && tx_word_reg[`BBDE_B_INT]) |=> (event_reg[1] || event_reg[2]))
      else $error("tx event missing");
endmodule
`default_nettype wire

// File: tb/bbde_line_model.sv
/*
 file: line-side model for the descriptor engine: receive strobes, buffer
 completion and transmit faults.
 assumes: shares pclk and presetn with the engine; drives at rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module bbde_line_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic tx_start, // engine starts a buffer
   input wire logic [15:0] tx_buf_len, // octets to send
   input wire logic fail_next, // next buffer ends in underrun
   output logic rx_char_valid, // char strobe
   output logic [7:0] rx_char, // char
   output logic rx_ctrl_char, // control char
   output logic rx_pll_fault, // recovery error
   output logic rx_overrun, // overrun
   output logic rx_carrier_lost, // carrier lost
   output logic tx_sent, // buffer sent
   output logic tx_starved, // underrun
   output logic tx_cts_lost // clear to send lost
);
   logic [16:0] left;
   logic busy;
   assign tx_cts_lost = 1'b0;
   initial begin
      rx_char_valid = 1'b0;
      rx_char = 8'h00;
      rx_ctrl_char = 1'b0;
      rx_pll_fault = 1'b0;
      rx_overrun = 1'b0;
      rx_carrier_lost = 1'b0;
   end
   // data inverted after the strobe so a stale byte never looks valid
   task send_char(input logic [7:0] c, input logic ctrl);
      @(posedge pclk);
      rx_char_valid <= 1'b1;
      rx_char <= c;
      rx_ctrl_char <= ctrl;
      @(posedge pclk);
      rx_char_valid <= 1'b0;
      rx_ctrl_char <= 1'b0;
      rx_char <= ~c;
   endtask
   // one-cycle line fault: 1 overrun, 2 recovery, 3 carrier
   task send_err(input logic [1:0] k);
      @(posedge pclk);
      rx_overrun <= (k == 2'h1);
      rx_pll_fault <= (k == 2'h2);
      rx_carrier_lost <= (k == 2'h3);
      @(posedge pclk);
      rx_overrun <= 1'b0;
      rx_pll_fault <= 1'b0;
      rx_carrier_lost <= 1'b0;
   endtask
   // slow answer: length plus three cycles after tx_start is sampled; a fault only when commanded
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         left <= 17'h00000;
         tx_sent <= 1'b0;
         tx_starved <= 1'b0;
      end else begin
         tx_sent <= 1'b0;
         tx_starved <= 1'b0;
         if (tx_start) begin
            busy <= 1'b1;
            left <= {1'b0, tx_buf_len} + 17'h00002;
         end else if (busy && left == 17'h00000) begin
            busy <= 1'b0;
            tx_sent <= !fail_next;
            tx_starved <= fail_next;
         end else if (busy) begin
            left <= left - 17'h00001;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/bbde_engine_test.sv
/*
 file: self-checking bench for the descriptor engine over apb.
 assumes: bbde_params.svh on the include path; line model in the same run.
*/
`timescale 1ns/1ps
`include "bbde_params.svh"
`default_nettype none
module bbde_engine_test;
   import bbde_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fail_next;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, rx_wr_addr, tx_buf_addr;
   logic rx_char_valid, rx_ctrl_char, rx_pll_fault, rx_overrun, rx_carrier_lost;
   logic [7:0] rx_char, rx_wr_data;
   logic [6:0] tx_char;
   logic tx_sent, tx_starved, tx_cts_lost, rx_wr_valid, tx_start, tx_lead_escape;
   logic tx_check_restart, tx_check_include, tx_escape_after, tx_parity_en, tx_parity_bit;
   logic [15:0] tx_buf_len;
   bbde_end_t tx_end_action;
   int num_errors, n_compared;
   bbde_engine i_bbde_engine (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .rx_ctrl_char(rx_ctrl_char), .rx_pll_fault(rx_pll_fault), .rx_overrun(rx_overrun),
      .rx_carrier_lost(rx_carrier_lost), .tx_char(tx_char), .tx_sent(tx_sent),
      .tx_starved(tx_starved), .tx_cts_lost(tx_cts_lost), .rx_wr_valid(rx_wr_valid),
      .rx_wr_addr(rx_wr_addr), .rx_wr_data(rx_wr_data), .tx_start(tx_start),
      .tx_buf_addr(tx_buf_addr), .tx_buf_len(tx_buf_len), .tx_lead_escape(tx_lead_escape),
      .tx_check_restart(tx_check_restart), .tx_check_include(tx_check_include),
      .tx_end_action(tx_end_action), .tx_escape_after(tx_escape_after),
      .tx_parity_en(tx_parity_en), .tx_parity_bit(tx_parity_bit));
   bbde_line_model i_bbde_line_model (.pclk(pclk), .presetn(presetn), .tx_start(tx_start),
      .tx_buf_len(tx_buf_len), .fail_next(fail_next), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .rx_ctrl_char(rx_ctrl_char), .rx_pll_fault(rx_pll_fault),
      .rx_overrun(rx_overrun), .rx_carrier_lost(rx_carrier_lost), .tx_sent(tx_sent),
      .tx_starved(tx_starved), .tx_cts_lost(tx_cts_lost));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task summarize;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // pready is sampled at the rising edge, the same edge at which a write lands
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            num_errors++;
            summarize();
         end
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      chk("read", q & m, e);
   endtask
   // bounded poll until every bit of m reads set
   task poll(input logic [11:0] a, input logic [31:0] m);
      int n;
      for (n = 0; n < 60; n++) begin
         apb(1'b0, a, 32'h00000000);
         if ((q & m) === m) return;
      end
      chk("poll", q & m, m);
      summarize();
   endtask
   task rxc(input logic [7:0] c, input logic ctrl, input logic [31:0] a);
      i_bbde_line_model.send_char(c, ctrl);
      @(negedge pclk);
      chk("rx strobe", {31'h0, rx_wr_valid}, 32'h00000001);
      chk("rx addr", rx_wr_addr, a);
      chk("rx data", {24'h0, rx_wr_data}, {24'h0, c});
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      tx_char = 7'h35;
      fail_next = 1'b0;
      num_errors = 0;
      n_compared = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(`BBDE_MAXLEN_OFF, 32'hffffffff, 32'h00000010);
      apb(1'b0, 12'h020, 32'h00000000);
      chk("unmapped", {31'h0, err}, 32'h00000001);
      // all four selects under sum check; 7'h35 has an even count of ones
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, `BBDE_MODE_OFF, 32'h0000000c | (p << 4));
         @(posedge pclk);
         @(negedge pclk);
         chk("parity", {30'h0, tx_parity_en, tx_parity_bit}, {31'h1, p != 1 && p != 2});
      end
      apb(1'b1, `BBDE_MODE_OFF, 32'h00000034);
      @(posedge pclk);
      @(negedge pclk);
      chk("no parity", {30'h0, tx_parity_en, tx_parity_bit}, 32'h00000000);
      // software fills descriptors while it still owns them
      apb(1'b1, 12'h100, 32'h00009000);
      apb(1'b1, 12'h104, 32'h00001001);
      apb(1'b1, 12'h108, 32'h0000b200);
      apb(1'b1, 12'h10c, 32'h00001100);
      apb(1'b1, 12'h110, 32'h00059de0);
      apb(1'b1, 12'h114, 32'h00002001);
      apb(1'b1, 12'h118, 32'h0040b200);
      apb(1'b1, 12'h11c, 32'h00003000);
      apb(1'b1, `BBDE_RXSTART_OFF, 32'h00000000);
      apb(1'b1, `BBDE_TXSTART_OFF, 32'h00000002);
      apb(1'b1, `BBDE_MODE_OFF, 32'h00000001);
      rxc(8'h41, 1'b0, 32'h00001001);
      rxc(8'h03, 1'b1, 32'h00001002);
      poll(`BBDE_EVENT_OFF, 32'h00000001);
      rd(12'h100, 32'hfffffbff, 32'h00021800);
      apb(1'b1, `BBDE_EVENT_OFF, 32'h0000000f);
      rxc(8'h55, 1'b0, 32'h00001100);
      i_bbde_line_model.send_err(2'h1);
      poll(`BBDE_EVENT_OFF, 32'h00000001);
      rd(12'h108, 32'hfffffbff, 32'h00013a02);
      rd(`BBDE_STATUS_OFF, 32'h0000000f, 32'h00000000);
      apb(1'b1, `BBDE_EVENT_OFF, 32'h0000000f);
      i_bbde_line_model.send_char(8'h66, 1'b0);
      @(negedge pclk);
      chk("no store", {31'h0, rx_wr_valid}, 32'h00000000);
      poll(`BBDE_EVENT_OFF, 32'h00000008);
      // enter hunt closes an open buffer with nothing stored in it
      apb(1'b1, 12'h100, 32'h00009000);
      apb(1'b1, `BBDE_CMD_OFF, 32'h00000001);
      poll(`BBDE_EVENT_OFF, 32'h00000001);
      rd(12'h100, 32'hfffffbff, 32'h00001800);
      // transmit: a full-featured buffer, then a reused one that underruns
      apb(1'b1, `BBDE_MODE_OFF, 32'h00000002);
      for (int n = 0; n < 100 && tx_start !== 1'b1; n++) @(negedge pclk);
      chk("tx start", {31'h0, tx_start}, 32'h00000001);
      chk("tx addr", tx_buf_addr, 32'h00002001);
      chk("tx len", {16'h0, tx_buf_len}, 32'h00000005);
      chk("tx flags", {26'h0, tx_lead_escape, tx_check_restart, tx_check_include,
         tx_escape_after, tx_end_action}, {26'h0, 4'he, END_BCS});
      poll(`BBDE_EVENT_OFF, 32'h00000002);
      fail_next <= 1'b1;
      rd(12'h110, 32'hffffffff, 32'h00051de0);
      poll(`BBDE_EVENT_OFF, 32'h00000004);
      rd(12'h118, 32'hffffffff, 32'h00403202);
      rd(`BBDE_STATUS_OFF, 32'h000000f0, 32'h00000020);
      // last buffer without check, idle fill chosen in the mode register
      apb(1'b1, `BBDE_MODE_OFF, 32'h00000042);
      apb(1'b1, 12'h110, 32'h00018800);
      for (int n = 0; n < 100 && tx_start !== 1'b1; n++) @(negedge pclk);
      chk("tx fill", {30'h0, tx_end_action}, {30'h0, END_IDLE});
      summarize();
   end
endmodule
`default_nettype wire
